// File: verilog/error_record_pkg.sv
/*
 * Shared constants and types for the error record status logic:
 * register offsets, status bit positions, reset values, error classes
 * and the structs that carry register requests and error events.
 * Assumes a single 64-bit register port; the offsets are byte addresses.
 */
package error_record_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] STATUS_OFFSET = 12'h010;
    localparam logic [11:0] SYNDROME_UPPER_OFFSET = 12'h028;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int LOCATION_VALID_BIT = 31;
    localparam int STATUS_VALID_BIT = 30;
    localparam int UNCORRECTED_BIT = 29;
    localparam int ABORT_SIGNALLED_BIT = 28;
    localparam int OVERFLOW_BIT = 27;
    localparam int MISC_VALID_BIT = 26;
    localparam int CORRECTED_MSB = 25;
    localparam int CORRECTED_LSB = 24;
    localparam int POSTPONED_BIT = 23;

    // ------------------------------------------------------------
    // corrected field codes
    // ------------------------------------------------------------
    localparam logic [1:0] CORR_NONE = 2'h0;
    localparam logic [1:0] CORR_TRANSIENT = 2'h1;
    localparam logic [1:0] CORR_GENERIC = 2'h2;
    localparam logic [1:0] CORR_PERSISTENT = 2'h3;
    localparam logic [1:0] CORR_CLEAR_ALL = 2'h3;

    // deferred errors never raise the abort flag in this node
    localparam logic ABORT_ON_POSTPONED = 1'b0;
    localparam logic [63:0] SYNDROME_UPPER_RESET = 64'h0000000000000000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // ordered so that a larger code is a higher priority class
    typedef enum logic [1:0] {
        CLASS_NONE = 2'h0,
        CLASS_CORRECTED = 2'h1,
        CLASS_POSTPONED = 2'h2,
        CLASS_UNCORRECTED = 2'h3
    } err_class_t;

    typedef struct packed {
        logic location_valid;
        logic status_valid;
        logic uncorrected_flag;
        logic abort_signalled;
        logic syndrome_overflow;
        logic misc_syndrome_valid;
        logic [1:0] corrected;
        logic postponed_flag;
    } status_flags_t;

    typedef struct packed {
        logic valid;
        err_class_t kind;
        logic [1:0] corr_kind;
        logic abort;
        logic addr_valid;
        logic misc_valid;
        logic [63:0] syndrome;
    } err_event_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [63:0] wdata;
    } reg_req_t;

    typedef struct packed {
        status_flags_t status;
        logic [63:0] syndrome_upper;
        logic [63:0] rd_data;
        logic rd_valid;
    } record_state_t;

    localparam status_flags_t STATUS_RESET = '0;
    localparam record_state_t STATE_RESET = '{
        status: STATUS_RESET,
        syndrome_upper: SYNDROME_UPPER_RESET,
        rd_data: 64'h0000000000000000,
        rd_valid: 1'b0
    };

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic err_class_t top_class(input status_flags_t s);
        err_class_t c;
        c = CLASS_NONE;
        if (s.uncorrected_flag) begin
            c = CLASS_UNCORRECTED;
        end else if (s.postponed_flag) begin
            c = CLASS_POSTPONED;
        end else if (s.corrected != CORR_NONE) begin
            c = CLASS_CORRECTED;
        end
        return c;
    endfunction

    function automatic logic [63:0] status_word(input status_flags_t s);
        logic [63:0] w;
        w = 64'h0000000000000000;
        w[LOCATION_VALID_BIT] = s.location_valid;
        w[STATUS_VALID_BIT] = s.status_valid;
        w[UNCORRECTED_BIT] = s.uncorrected_flag;
        w[ABORT_SIGNALLED_BIT] = s.abort_signalled;
        w[OVERFLOW_BIT] = s.syndrome_overflow;
        w[MISC_VALID_BIT] = s.misc_syndrome_valid;
        w[CORRECTED_MSB:CORRECTED_LSB] = s.corrected;
        w[POSTPONED_BIT] = s.postponed_flag;
        return w;
    endfunction

endpackage

// File: verilog/status_write_filter.sv
/*
 * Applies a software write to the status flags with write-one-to-clear
 * and the write-ignore protection of the valid and type bits.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
module status_write_filter
    import error_record_pkg::*;
(
    input wire status_flags_t cur_i,
    input wire logic wr_i,
    input wire logic [63:0] wdata_i,
    output status_flags_t after_o
);

    // ------------------------------------------------------------
    // protection decode and clearing
    // ------------------------------------------------------------
    always_comb begin
        logic clr_overflow;
        logic type_ok;
        logic top_clr;
        clr_overflow = wdata_i[OVERFLOW_BIT];
        type_ok = !cur_i.syndrome_overflow || clr_overflow; // [RL8]
        top_clr = 1'b1;
        // the valid bits only move when the highest class is cleared too;
        // a class flag held by overflow is not cleared, so it protects them
        case (top_class(cur_i)) // [RL22]
            CLASS_UNCORRECTED: top_clr = wdata_i[UNCORRECTED_BIT] && type_ok;
            CLASS_POSTPONED: top_clr = wdata_i[POSTPONED_BIT] && type_ok;
            CLASS_CORRECTED: top_clr = type_ok && (wdata_i[CORRECTED_MSB:CORRECTED_LSB] == CORR_CLEAR_ALL);
            default: top_clr = 1'b1;
        endcase
        after_o = cur_i;
        if (wr_i) begin
            // no corrected counter here, so nothing else moves with overflow
            if (clr_overflow) begin
                after_o.syndrome_overflow = 1'b0; // [RL9] [RL15]
            end
            if (type_ok) begin
                if (wdata_i[UNCORRECTED_BIT]) begin
                    after_o.uncorrected_flag = 1'b0; // [RL9]
                end
                if (wdata_i[POSTPONED_BIT]) begin
                    after_o.postponed_flag = 1'b0; // [RL21]
                end
                // partial patterns leave the field alone
                if (wdata_i[CORRECTED_MSB:CORRECTED_LSB] == CORR_CLEAR_ALL) begin
                    after_o.corrected = CORR_NONE;
                end
            end
            if (top_clr) begin // [RL6]
                if (wdata_i[LOCATION_VALID_BIT]) begin
                    after_o.location_valid = 1'b0;
                end
                if (wdata_i[STATUS_VALID_BIT]) begin
                    after_o.status_valid = 1'b0;
                end
                if (wdata_i[ABORT_SIGNALLED_BIT]) begin
                    after_o.abort_signalled = 1'b0;
                end
                if (wdata_i[MISC_VALID_BIT]) begin
                    after_o.misc_syndrome_valid = 1'b0;
                end
            end
        end
    end

endmodule // status_write_filter

// File: verilog/error_event_merge.sv
/*
 * Merges one reported error into the status flags: sets the class
 * flags, decides overflow and whether the new error takes the record.
 * Combinational; expects the flags after any same-cycle write, so a
 * new error always wins over a clear.
 */
`timescale 1ns/100ps
module error_event_merge
    import error_record_pkg::*;
(
    input wire status_flags_t st_i,
    input wire err_event_t ev_i,
    output status_flags_t nxt_o,
    output logic capture_o
);

    // ------------------------------------------------------------
    // class flags, overflow and capture
    // ------------------------------------------------------------
    always_comb begin
        err_class_t top;
        logic [1:0] corr;
        top = top_class(st_i);
        // unclassified corrections are reported as plain corrected
        corr = (ev_i.corr_kind == CORR_NONE) ? CORR_GENERIC : ev_i.corr_kind; // [RL20]
        capture_o = ev_i.valid && (ev_i.kind > top);
        nxt_o = st_i;
        if (ev_i.valid && ev_i.kind != CLASS_NONE) begin
            nxt_o.status_valid = 1'b1; // [RL5]
            case (ev_i.kind)
                CLASS_UNCORRECTED: nxt_o.uncorrected_flag = 1'b1; // [RL7]
                CLASS_POSTPONED: nxt_o.postponed_flag = 1'b1; // [RL21]
                default: begin
                    if (st_i.corrected == CORR_NONE || st_i.corrected == corr) begin
                        nxt_o.corrected = corr;
                    end else begin
                        nxt_o.corrected = CORR_GENERIC;
                    end
                end
            endcase
            // equal or higher class already held: a syndrome is lost
            if (ev_i.kind <= top) begin
                nxt_o.syndrome_overflow = 1'b1; // [RL12] [RL13] [RL16]
            end else begin
                nxt_o.syndrome_overflow = 1'b0; // [RL14]
                nxt_o.location_valid = ev_i.addr_valid; // [RL4]
                nxt_o.misc_syndrome_valid = ev_i.misc_valid; // [RL18]
                nxt_o.abort_signalled = ev_i.abort && (ev_i.kind == CLASS_UNCORRECTED
                    || (ev_i.kind == CLASS_POSTPONED && ABORT_ON_POSTPONED)); // [RL10]
            end
        end
    end

endmodule // error_event_merge

// File: verilog/error_record_status.sv
/*
 * Error record status logic for one error-recording node: the primary
 * status register and the upper miscellaneous syndrome register.
 * Assumes the node's error detection and the register port run on
 * ref_clk_i; requests and events are single-cycle strobes.
 */
//
// Summary of operation
// (RL1) syndrome upper ignores writes while misc valid
// (RL2) syndrome upper is 64 bits, node defined
// (RL3) status upper bits and 19:16 read zero
// (RL4) bit 31 location valid, cold reset zero
// (RL5) bit 30 status valid set on recording
// (RL6) valid bits protected unless top class cleared
// (RL7) bit 29 set on uncorrected error
// (RL8) uncorrected flag protected while overflow set
// (RL9) flags clear on write one only
// (RL10) bit 28 set when abort returned to master
// (RL11) abort flag meaningless without its class
// (RL12) bit 27 set when syndrome is lost
// (RL13) overflow also set under higher class
// (RL14) overflow cleared by higher class recording
// (RL15) no counter, so no cross effects
// (RL16) overflow one means syndrome was discarded
// (RL17) class flags meaningless while status invalid
// (RL18) bit 26 misc valid, cold reset zero
// (RL19) software clears valid bits after reading
// (RL20) corrected field codes, unclassified gives 0b10
// (RL21) bit 23 postponed flag set and cleared
// (RL22) priority uncorrected over postponed over corrected
`timescale 1ns/100ps
module error_record_status
    import error_record_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire reg_req_t reg_req_i,
    input wire err_event_t err_event_i,
    output logic [63:0] rd_data_o,
    output logic rd_valid_o,
    output status_flags_t status_o
);

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    record_state_t state_reg;
    record_state_t state_next;
    status_flags_t written;
    status_flags_t merged;
    logic capture;
    logic status_wr;
    logic syndrome_wr;

    assign status_wr = reg_req_i.wr && (reg_req_i.addr == STATUS_OFFSET);
    assign syndrome_wr = reg_req_i.wr && (reg_req_i.addr == SYNDROME_UPPER_OFFSET);

    // ------------------------------------------------------------
    // write first, then the event, so a set beats a clear
    // ------------------------------------------------------------
    status_write_filter u_write_filter (
        .cur_i(state_reg.status),
        .wr_i(status_wr),
        .wdata_i(reg_req_i.wdata),
        .after_o(written)
    );

    error_event_merge u_event_merge (
        .st_i(written),
        .ev_i(err_event_i),
        .nxt_o(merged),
        .capture_o(capture)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.status = merged;
        state_next.rd_valid = reg_req_i.rd;
        state_next.rd_data = 64'h0000000000000000;
        // stale flags are returned as stored; software checks validity
        if (reg_req_i.rd) begin // [RL11] [RL17]
            case (reg_req_i.addr)
                STATUS_OFFSET: state_next.rd_data = status_word(state_reg.status); // [RL3]
                SYNDROME_UPPER_OFFSET: state_next.rd_data = state_reg.syndrome_upper; // [RL2]
                default: state_next.rd_data = 64'h0000000000000000;
            endcase
        end
        // latest-error syndrome is locked while it is valid
        if (syndrome_wr && !state_reg.status.misc_syndrome_valid) begin // [RL1]
            state_next.syndrome_upper = reg_req_i.wdata; // [RL2]
        end
        if (capture && err_event_i.misc_valid) begin
            state_next.syndrome_upper = err_event_i.syndrome; // [RL2]
        end
    end

    // ------------------------------------------------------------
    // registers; rst_i is the cold reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= STATE_RESET; // [RL4] [RL5] [RL18]
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data_o = state_reg.rd_data;
    assign rd_valid_o = state_reg.rd_valid;
    assign status_o = state_reg.status;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    logic quiet;
    assign quiet = !reg_req_i.wr;

    sequence s_uncorrected_event;
        err_event_i.valid && err_event_i.kind == CLASS_UNCORRECTED && quiet;
    endsequence

    sequence s_status_read;
        reg_req_i.rd && reg_req_i.addr == STATUS_OFFSET;
    endsequence

    property p_reserved_zero;
        s_status_read |=> rd_valid_o && rd_data_o[63:32] == 32'h00000000 && rd_data_o[19:16] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero"); // [RL3]

    property p_cold_reset;
        disable iff (1'b0)
        rst_i |=> !status_o.location_valid && !status_o.status_valid && !status_o.misc_syndrome_valid;
    endproperty
    a_cold_reset: assert property (p_cold_reset) else $error("valid bits not cleared by reset"); // [RL4] [RL18]

    property p_valid_set;
        err_event_i.valid && err_event_i.kind != CLASS_NONE |=> status_o.status_valid;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("status valid not set by error"); // [RL5]

    property p_uncorrected_set;
        s_uncorrected_event |=> status_o.uncorrected_flag ##1 (status_o.uncorrected_flag || !$past(quiet));
    endproperty
    a_uncorrected_set: assert property (p_uncorrected_set) else $error("uncorrected flag not set"); // [RL7]

    property p_overflow_repeat;
        (s_uncorrected_event and status_o.uncorrected_flag) |=> status_o.syndrome_overflow;
    endproperty
    a_overflow_repeat: assert property (p_overflow_repeat) else $error("overflow missed on second error"); // [RL12]

    property p_overflow_cleared;
        err_event_i.valid && err_event_i.kind == CLASS_UNCORRECTED && quiet
            && !status_o.uncorrected_flag |=> !status_o.syndrome_overflow;
    endproperty
    a_overflow_cleared: assert property (p_overflow_cleared) else $error("overflow kept on higher class"); // [RL14]

    property p_valid_protect;
        status_wr && status_o.uncorrected_flag && !reg_req_i.wdata[UNCORRECTED_BIT]
            && !err_event_i.valid |=> $stable(status_o.status_valid) && $stable(status_o.location_valid)
            && $stable(status_o.misc_syndrome_valid) && $stable(status_o.abort_signalled);
    endproperty
    a_valid_protect: assert property (p_valid_protect) else $error("protected valid bit changed"); // [RL6]

    property p_uncorrected_protect;
        status_wr && status_o.syndrome_overflow && !reg_req_i.wdata[OVERFLOW_BIT]
            && !err_event_i.valid |=> $stable(status_o.uncorrected_flag) && status_o.syndrome_overflow;
    endproperty
    a_uncorrected_protect: assert property (p_uncorrected_protect) else $error("flag cleared under overflow"); // [RL8]

    property p_write_one_clears;
        status_wr && top_class(status_o) == CLASS_NONE && reg_req_i.wdata[STATUS_VALID_BIT]
            && !err_event_i.valid |=> !status_o.status_valid;
    endproperty
    a_write_one_clears: assert property (p_write_one_clears) else $error("write one did not clear"); // [RL9]

    property p_write_zero_keeps;
        status_wr && reg_req_i.wdata == 64'h0000000000000000 && !err_event_i.valid |=> $stable(status_o);
    endproperty
    a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("write of zero changed status"); // [RL9]

    property p_abort_capture;
        s_uncorrected_event and (err_event_i.abort && !status_o.uncorrected_flag)
            |=> status_o.abort_signalled;
    endproperty
    a_abort_capture: assert property (p_abort_capture) else $error("abort flag not recorded"); // [RL10]

    property p_syndrome_locked;
        syndrome_wr && status_o.misc_syndrome_valid && !capture |=> $stable(state_reg.syndrome_upper);
    endproperty
    a_syndrome_locked: assert property (p_syndrome_locked) else $error("locked syndrome overwritten"); // [RL1]

    property p_unclassified_corrected;
        err_event_i.valid && err_event_i.kind == CLASS_CORRECTED && err_event_i.corr_kind == CORR_NONE
            && status_o.corrected == CORR_NONE && quiet |=> status_o.corrected == CORR_GENERIC;
    endproperty
    a_unclassified_corrected: assert property (p_unclassified_corrected) else $error("bad corrected code"); // [RL20]

    property p_postponed_set;
        err_event_i.valid && err_event_i.kind == CLASS_POSTPONED |=> status_o.postponed_flag;
    endproperty
    a_postponed_set: assert property (p_postponed_set) else $error("postponed flag not set"); // [RL21]

endmodule // error_record_status

// File: bench/error_node_model.sv
/*
 * Error source model: the detection logic of the node, reporting one
 * error per raise call as a single-cycle strobe.
 * Assumes the record samples err_event_o on rising ref_clk_i edges.
 */
`timescale 1ns/100ps
module error_node_model
    import error_record_pkg::*;
(
    input wire logic ref_clk_i,
    output err_event_t err_event_o
);
    // ----
    // event driver
    // ----
    // quiet until the first report
    initial begin
        err_event_o = '0;
    end

    // syndrome inverted after the strobe so stale data never matches
    task automatic raise(input logic [1:0] kind, input logic [1:0] corr, input logic ab,
        input logic av, input logic mv, input logic [63:0] syn);
        @(posedge ref_clk_i);
        err_event_o <= '{valid: 1'b1, kind: err_class_t'(kind), corr_kind: corr, abort: ab,
            addr_valid: av, misc_valid: mv, syndrome: syn};
        @(posedge ref_clk_i);
        err_event_o.valid <= 1'b0;
        err_event_o.syndrome <= ~syn;
        #1;
    endtask
endmodule // error_node_model

// File: bench/error_record_status_logic_bench.sv
/*
 * Self-checking bench for the error record status logic: a table of
 * single errors on an empty record, then protection, overflow and
 * reset cases by hand.
 * Assumes the record's package and the error source model.
 */
`timescale 1ns/100ps
module error_record_status_logic_bench
    import error_record_pkg::*;
;
    typedef struct packed {
        logic [1:0] kind;
        logic [1:0] corr;
        logic ab;
        logic av;
        logic mv;
        logic [31:0] exp;
    } row_t;

    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_t req = '0;
    err_event_t ev;
    logic [63:0] rd_data_o;
    logic rd_valid_o;
    status_flags_t status_o;
    int errors = 0;
    int total_checks = 0;
    row_t rows [9] = '{
        '{2'h3, 2'h0, 1'b1, 1'b1, 1'b1, 32'hF4000000},
        '{2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 32'h60000000},
        '{2'h2, 2'h0, 1'b1, 1'b1, 1'b0, 32'hC0800000},
        '{2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 32'h44800000},
        '{2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 32'h41000000},
        '{2'h1, 2'h2, 1'b0, 1'b1, 1'b0, 32'hC2000000},
        '{2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 32'h43000000},
        '{2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 32'h42000000},
        '{2'h0, 2'h2, 1'b1, 1'b1, 1'b1, 32'h00000000}
    };

    // 10 MHz node clock
    always #50 ref_clk_i = ~ref_clk_i;

    error_record_status u_error_record_status (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .reg_req_i(req),
        .err_event_i(ev),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .status_o(status_o)
    );

    error_node_model u_error_node_model (
        .ref_clk_i(ref_clk_i),
        .err_event_o(ev)
    );

    // ----
    // compare and bus tasks
    // ----
    task automatic chk_st(input logic [31:0] exp);
        total_checks++;
        if (status_o !== exp[31:23]) begin
            errors++;
            $display("BAD t=%0t status got=%h exp=%h", $time, status_o, exp[31:23]);
        end
    endtask

    task automatic chk_rd(input logic v, input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (v !== 1'b1 || got !== exp) begin
            errors++;
            $display("BAD t=%0t read got=%h exp=%h valid=%h", $time, got, exp, v);
        end
    endtask

    // data scrambled after the strobe so it is not reused; the address is left as written
    task automatic wr_reg(input logic [11:0] a, input logic [63:0] d);
        @(posedge ref_clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
        req.wdata <= ~d;
        #1;
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [63:0] exp);
        @(posedge ref_clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        req.addr <= ~a;
        #1;
        chk_rd(rd_valid_o, rd_data_o, exp);
    endtask

    // software handing the record back once read
    task automatic clear_all();
        wr_reg(STATUS_OFFSET, 64'hFFFFFFFFFFFFFFFF);
        chk_st(32'h0);
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk_st(32'h0);
        rd_reg(STATUS_OFFSET, 64'h0);
        rd_reg(SYNDROME_UPPER_OFFSET, 64'h0);
        rd_reg(12'h018, 64'h0);
        // one error of each class and code on an empty record
        foreach (rows[i]) begin
            u_error_node_model.raise(rows[i].kind, rows[i].corr, rows[i].ab, rows[i].av, rows[i].mv, 64'h5);
            chk_st(rows[i].exp);
            rd_reg(STATUS_OFFSET, {32'h0, rows[i].exp});
            clear_all();
        end
        // syndrome writable while free, locked while misc valid
        wr_reg(SYNDROME_UPPER_OFFSET, 64'hA5A5A5A5A5A5A5A5);
        rd_reg(SYNDROME_UPPER_OFFSET, 64'hA5A5A5A5A5A5A5A5);
        u_error_node_model.raise(2'h3, 2'h0, 1'b1, 1'b1, 1'b1, 64'h0123456789ABCDEF);
        chk_st(32'hF4000000);
        wr_reg(SYNDROME_UPPER_OFFSET, 64'hFFFF0000FFFF0000);
        rd_reg(SYNDROME_UPPER_OFFSET, 64'h0123456789ABCDEF);
        // valid bits held unless the top class clears in the same write
        wr_reg(STATUS_OFFSET, 64'h0);
        chk_st(32'hF4000000);
        wr_reg(STATUS_OFFSET, 64'hD4000000);
        chk_st(32'hF4000000);
        wr_reg(STATUS_OFFSET, 64'h40800000);
        chk_st(32'hF4000000);
        wr_reg(STATUS_OFFSET, 64'h60000000);
        chk_st(32'h94000000);
        clear_all();
        // repeated uncorrected error overflows and guards its flag
        u_error_node_model.raise(2'h3, 2'h0, 1'b1, 1'b1, 1'b1, 64'h77);
        u_error_node_model.raise(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 64'h88);
        chk_st(32'hFC000000);
        // top class held by overflow keeps the valid bits too
        wr_reg(STATUS_OFFSET, 64'hF4000000);
        chk_st(32'hFC000000);
        wr_reg(STATUS_OFFSET, 64'h28000000);
        chk_st(32'hD4000000);
        // cold reset in mid-run with a full record
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk_st(32'h0);
        rd_reg(SYNDROME_UPPER_OFFSET, 64'h0);
        // overflow per class, cleared by a higher class, set under it
        u_error_node_model.raise(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 64'h1);
        u_error_node_model.raise(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 64'h2);
        chk_st(32'h48800000);
        clear_all();
        u_error_node_model.raise(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 64'h3);
        u_error_node_model.raise(2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 64'h4);
        chk_st(32'h4A000000);
        u_error_node_model.raise(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 64'h5);
        chk_st(32'h62000000);
        u_error_node_model.raise(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 64'h6);
        chk_st(32'h6A000000);
        // a clearing write and a new error in one cycle: the error is kept
        fork
            wr_reg(STATUS_OFFSET, 64'hFFFFFFFFFFFFFFFF);
            u_error_node_model.raise(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 64'h9);
        join
        chk_st(32'h60000000);
        clear_all();
        summarize();
    end

    // cut a hang short well past the expected run of about 130 cycles
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        errors++;
        summarize();
    end
endmodule // error_record_status_logic_bench
